// File: hdl/clock_unit_irq_enable_core_gates.sv
// Top of the clock unit interrupt enable and core clock gate registers
// Function
// - Enable bit 6 lets calibration overflow flag raise interrupt; resets 0.
// - Enable bit 5 lets calibration complete flag raise interrupt; resets 0.
// - Enable bit 4 lets auxiliary fast RC ready raise interrupt; resets 0.
// - Enable bit 3 lets slow crystal ready raise interrupt; resets 0.
// - Enable bit 2 lets slow RC ready raise interrupt; resets 0.
// - Enable bit 1 lets fast crystal ready raise interrupt; resets 0.
// - Enable bit 0 lets fast RC ready raise interrupt; resets 0.
// - Gate bit 2 supplies clock to low energy bus interface; resets 0.
// - Gate bit 1 ungates the DMA controller clock; resets 0.
// - Gate bit 0 ungates the AES accelerator clock; resets 0.
// - Writing one to flag set register sets matching flags.
// - Writing one to flag clear register clears matching flags unless their event fires that cycle.
module clock_unit_irq_enable_core_gates
   import cuieg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic calibrationOverflow,
   input wire logic calibrationComplete,
   input wire logic auxFastRcOscReady,
   input wire logic slowCrystalOscReady,
   input wire logic slowRcOscReady,
   input wire logic fastCrystalOscReady,
   input wire logic fastRcOscReady,
   output logic irq,
   output logic lowEnergyBusInterfaceClockEn,
   output logic dmaClockEn,
   output logic aesClockEn
);
   cuieg_reg_if regBus ();

   logic [IRQ_W-1:0] interruptEnableMask;
   logic [GATE_W-1:0] coreClockGateEnable;
   logic [IRQ_W-1:0] flags;
   logic [IRQ_W-1:0] events;
   logic [IRQ_W-1:0] swSet;
   logic [IRQ_W-1:0] swClear;
   logic lowLane;

   function automatic logic isMapped(input logic [7:0] a);
      return a == OFS_FLAG_STATUS || a == OFS_FLAG_SET ||
         a == OFS_FLAG_CLEAR || a == OFS_IRQ_ENABLE || a == OFS_CORE_GATE;
   endfunction : isMapped

   function automatic logic hitWrite(input logic [7:0] ofs);
      return regBus.wrEn && regBus.wrAddr == ofs && regBus.wrStrb[0];
   endfunction : hitWrite

   ////////////////////////////////////////////////////////////////////////
   // Bus front end
   cuieg_axil_slave cuieg_axil_slave_i (
      .clk(clk),
      .rst(rst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .port(regBus)
   );

   assign lowLane = regBus.wrStrb[0];

   ////////////////////////////////////////////////////////////////////////
   // Interrupt enable mask
   always_ff @(posedge clk) begin
      if (rst) begin
         interruptEnableMask <= IRQ_RESET;
      end else if (hitWrite(OFS_IRQ_ENABLE)) begin
         // Upper bits are dropped; software keeps them zero
         interruptEnableMask <= regBus.wrData[IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core clock gate enables
   always_ff @(posedge clk) begin
      if (rst) begin
         coreClockGateEnable <= GATE_RESET;
      end else if (hitWrite(OFS_CORE_GATE)) begin
         coreClockGateEnable <= regBus.wrData[GATE_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lowEnergyBusInterfaceClockEn <= 1'b0;
         dmaClockEn <= 1'b0;
         aesClockEn <= 1'b0;
      end else begin
         lowEnergyBusInterfaceClockEn <=
            coreClockGateEnable[BIT_LE_BUS];
         dmaClockEn <= coreClockGateEnable[BIT_DMA];
         aesClockEn <= coreClockGateEnable[BIT_AES];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt flags
   always_comb begin
      events = '0;
      events[BIT_CAL_OVERFLOW] = calibrationOverflow;
      events[BIT_CAL_COMPLETE] = calibrationComplete;
      events[BIT_AUX_FAST_RC] = auxFastRcOscReady;
      events[BIT_SLOW_CRYSTAL] = slowCrystalOscReady;
      events[BIT_SLOW_RC] = slowRcOscReady;
      events[BIT_FAST_CRYSTAL] = fastCrystalOscReady;
      events[BIT_FAST_RC] = fastRcOscReady;
   end

   assign swSet = hitWrite(OFS_FLAG_SET) ?
      regBus.wrData[IRQ_W-1:0] : '0;
   assign swClear = hitWrite(OFS_FLAG_CLEAR) ?
      regBus.wrData[IRQ_W-1:0] : '0;

   cuieg_irq_flags #(
      .WIDTH(IRQ_W)
   ) cuieg_irq_flags_i (
      .clk(clk),
      .rst(rst),
      .events(events),
      .swSet(swSet),
      .swClear(swClear),
      .flags(flags)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & interruptEnableMask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      regBus.rdData = 32'h0000_0000;
      unique case (regBus.rdAddr)
         OFS_FLAG_STATUS: regBus.rdData[IRQ_W-1:0] = flags;
         OFS_IRQ_ENABLE: regBus.rdData[IRQ_W-1:0] = interruptEnableMask;
         OFS_CORE_GATE: regBus.rdData[GATE_W-1:0] = coreClockGateEnable;
         default: regBus.rdData = 32'h0000_0000;
      endcase
   end

   assign regBus.rdErr = !isMapped(regBus.rdAddr);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_irq_follows_mask: assert property (@(posedge clk) disable iff (rst)
      ##1 irq == |($past(flags) & $past(interruptEnableMask)))
      else $error("irq does not match flags and mask");
   a_enable_write_lands: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_IRQ_ENABLE) |=>
      interruptEnableMask == $past(regBus.wrData[IRQ_W-1:0]))
      else $error("enable mask write lost");
   a_gate_write_lands: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_CORE_GATE) |=> ##1
      aesClockEn == $past(regBus.wrData[BIT_AES], 2))
      else $error("aes gate not following write");
   a_dma_gate_out: assert property (@(posedge clk) disable iff (rst)
      ##1 dmaClockEn == $past(coreClockGateEnable[BIT_DMA]))
      else $error("dma gate out of step");
   a_le_gate_out: assert property (@(posedge clk) disable iff (rst)
      ##1 lowEnergyBusInterfaceClockEn ==
      $past(coreClockGateEnable[BIT_LE_BUS]))
      else $error("low energy gate out of step");
   a_flag_set_write: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_FLAG_SET) && regBus.wrData[BIT_SLOW_RC] |=>
      flags[BIT_SLOW_RC])
      else $error("flag set write ignored");
   a_flag_clear_write: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_FLAG_CLEAR) && regBus.wrData[BIT_FAST_RC] &&
      !events[BIT_FAST_RC] |=> !flags[BIT_FAST_RC])
      else $error("flag clear write ignored");
   a_masked_quiet: assert property (@(posedge clk) disable iff (rst)
      interruptEnableMask == '0 |=> !irq)
      else $error("irq with all enables off");
   a_lane_unused: assert property (@(posedge clk) disable iff (rst)
      regBus.wrEn && !lowLane |=>
      $stable(interruptEnableMask))
      else $error("write without low lane changed mask");
   a_aes_gate_out: assert property (@(posedge clk) disable iff (rst)
      ##1 aesClockEn == $past(coreClockGateEnable[BIT_AES]))
      else $error("aes gate out of step");
   a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
      regBus.wrEn && !isMapped(regBus.wrAddr) |=>
      $stable(interruptEnableMask) && $stable(coreClockGateEnable))
      else $error("write to unmapped place changed a register");

   ////////////////////////////////////////////////////////////////////////
   // Per-source enable checks
   a_cal_ovf_irq: assert property (@(posedge clk) disable iff (rst)
      flags[BIT_CAL_OVERFLOW] && interruptEnableMask[BIT_CAL_OVERFLOW]
      |=> irq)
      else $error("calibration overflow enabled but irq low");
   a_cal_done_irq: assert property (@(posedge clk) disable iff (rst)
      flags[BIT_CAL_COMPLETE] && interruptEnableMask[BIT_CAL_COMPLETE]
      |=> irq)
      else $error("calibration complete enabled but irq low");
   a_aux_rc_irq: assert property (@(posedge clk) disable iff (rst)
      flags[BIT_AUX_FAST_RC] && interruptEnableMask[BIT_AUX_FAST_RC]
      |=> irq)
      else $error("aux fast rc ready enabled but irq low");
   a_slow_xtal_irq: assert property (@(posedge clk) disable iff (rst)
      flags[BIT_SLOW_CRYSTAL] && interruptEnableMask[BIT_SLOW_CRYSTAL]
      |=> irq)
      else $error("slow crystal ready enabled but irq low");
   a_slow_rc_irq: assert property (@(posedge clk) disable iff (rst)
      flags[BIT_SLOW_RC] && interruptEnableMask[BIT_SLOW_RC]
      |=> irq)
      else $error("slow rc ready enabled but irq low");
   a_fast_xtal_irq: assert property (@(posedge clk) disable iff (rst)
      flags[BIT_FAST_CRYSTAL] && interruptEnableMask[BIT_FAST_CRYSTAL]
      |=> irq)
      else $error("fast crystal ready enabled but irq low");
   a_fast_rc_irq: assert property (@(posedge clk) disable iff (rst)
      flags[BIT_FAST_RC] && interruptEnableMask[BIT_FAST_RC]
      |=> irq)
      else $error("fast rc ready enabled but irq low");
   a_irq_needs_flag: assert property (@(posedge clk) disable iff (rst)
      (flags & interruptEnableMask) == '0 |=> !irq)
      else $error("irq high with no enabled flag");

   ////////////////////////////////////////////////////////////////////////
   // Reset, hold and gate write checks
   a_reset_mask: assert property (@(posedge clk)
      rst |=> interruptEnableMask == IRQ_RESET)
      else $error("enable mask not cleared by reset");
   a_reset_gates: assert property (@(posedge clk)
      rst |=> coreClockGateEnable == GATE_RESET &&
      !aesClockEn && !dmaClockEn &&
      !lowEnergyBusInterfaceClockEn)
      else $error("gates not cleared by reset");
   a_mask_holds: assert property (@(posedge clk) disable iff (rst)
      !hitWrite(OFS_IRQ_ENABLE) |=> $stable(interruptEnableMask))
      else $error("enable mask changed without a write");
   a_gate_holds: assert property (@(posedge clk) disable iff (rst)
      !hitWrite(OFS_CORE_GATE) |=> $stable(coreClockGateEnable))
      else $error("gate register changed without a write");
   a_gate_reg_write: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_CORE_GATE) |=>
      coreClockGateEnable == $past(regBus.wrData[GATE_W-1:0]))
      else $error("gate register write lost");
   a_dma_write_lands: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_CORE_GATE) |=> ##1
      dmaClockEn == $past(regBus.wrData[BIT_DMA], 2))
      else $error("dma gate not following write");
   a_le_write_lands: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_CORE_GATE) |=> ##1
      lowEnergyBusInterfaceClockEn ==
      $past(regBus.wrData[BIT_LE_BUS], 2))
      else $error("low energy gate not following write");

   ////////////////////////////////////////////////////////////////////////
   // Flag write checks over all bits
   a_set_all_bits: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_FLAG_SET) |=>
      (flags & $past(regBus.wrData[IRQ_W-1:0])) ==
      $past(regBus.wrData[IRQ_W-1:0]))
      else $error("flag set write missed a bit");
   a_clear_all_bits: assert property (@(posedge clk) disable iff (rst)
      hitWrite(OFS_FLAG_CLEAR) |=>
      (flags & $past(regBus.wrData[IRQ_W-1:0]) & ~$past(events)) ==
      '0)
      else $error("flag clear write missed a bit");
   a_flags_hold: assert property (@(posedge clk) disable iff (rst)
      swSet == '0 && swClear == '0 && events == '0 |=>
      $stable(flags))
      else $error("flags changed with no cause");
endmodule : clock_unit_irq_enable_core_gates

// File: hdl/cuieg_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into register strobes
module cuieg_axil_slave
   import cuieg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   cuieg_reg_if.bus port
);
   logic haveAw;
   logic haveW;
   logic [7:0] awHeld;
   logic [31:0] wHeld;
   logic [3:0] sHeld;
   logic next_haveAw;
   logic next_haveW;
   logic next_bvalid;
   logic next_rvalid;
   logic next_wrEn;

   ////////////////////////////////////////////////////////////////////////
   // Write path: address and data taken in either order
   always_ff @(posedge clk) begin
      if (rst) begin
         haveAw <= 1'b0;
         awHeld <= 8'h00;
      end else if (awvalid && awready) begin
         haveAw <= 1'b1;
         awHeld <= awaddr;
      end else if (port.wrEn) begin
         haveAw <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         haveW <= 1'b0;
         wHeld <= 32'h0000_0000;
         sHeld <= 4'h0;
      end else if (wvalid && wready) begin
         haveW <= 1'b1;
         wHeld <= wdata;
         sHeld <= wstrb;
      end else if (port.wrEn) begin
         haveW <= 1'b0;
      end
   end

   assign port.wrEn = haveAw && haveW && !bvalid;

   // Readies come from flops, so they are worked out from next state
   assign next_haveAw = (awvalid && awready) || (haveAw && !port.wrEn);
   assign next_haveW = (wvalid && wready) || (haveW && !port.wrEn);
   assign next_bvalid = port.wrEn || (bvalid && !bready);
   assign next_rvalid = (arvalid && arready && !port.wrEn) ||
      (rvalid && !rready);
   assign next_wrEn = next_haveAw && next_haveW && !next_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
      end else begin
         awready <= !next_haveAw && !next_bvalid;
         wready <= !next_haveW && !next_bvalid;
         // No read is taken in the cycle a write commits
         arready <= !next_rvalid && !next_wrEn;
      end
   end
   assign port.wrAddr = awHeld;
   assign port.wrData = wHeld;
   assign port.wrStrb = sHeld;

   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (port.wrEn) begin
         bvalid <= 1'b1;
         bresp <= port.rdErr ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path
   assign port.rdAddr = port.wrEn ? awHeld : araddr;

   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready && !port.wrEn) begin
         rvalid <= 1'b1;
         rdata <= port.rdData;
         rresp <= port.rdErr ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : cuieg_axil_slave

// File: hdl/cuieg_irq_flags.sv
// Sticky interrupt flags with set-wins-over-clear priority
module cuieg_irq_flags
   import cuieg_pkg::*;
#(
   parameter int WIDTH = IRQ_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] events,
   input wire logic [WIDTH-1:0] swSet,
   input wire logic [WIDTH-1:0] swClear,
   output logic [WIDTH-1:0] flags
);
   always_ff @(posedge clk) begin
      if (rst) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~swClear) | swSet | events;
      end
   end

   a_set_beats_clear: assert property (@(posedge clk) disable iff (rst)
      (events != '0) |=> ((flags & $past(events)) == $past(events)))
      else $error("event lost against clear");
endmodule : cuieg_irq_flags

// File: hdl/cuieg_pkg.sv
// Package of offsets, field positions and reset values for the clock unit
package cuieg_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_FLAG_STATUS = 8'h30;
   localparam logic [7:0] OFS_FLAG_SET = 8'h34;
   localparam logic [7:0] OFS_FLAG_CLEAR = 8'h38;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h3C;
   localparam logic [7:0] OFS_CORE_GATE = 8'h40;
   localparam int IRQ_W = 7;
   localparam int GATE_W = 3;
   localparam int BIT_CAL_OVERFLOW = 6;
   localparam int BIT_CAL_COMPLETE = 5;
   localparam int BIT_AUX_FAST_RC = 4;
   localparam int BIT_SLOW_CRYSTAL = 3;
   localparam int BIT_SLOW_RC = 2;
   localparam int BIT_FAST_CRYSTAL = 1;
   localparam int BIT_FAST_RC = 0;
   localparam int BIT_LE_BUS = 2;
   localparam int BIT_DMA = 1;
   localparam int BIT_AES = 0;
   localparam logic [6:0] IRQ_RESET = 7'h00;
   localparam logic [2:0] GATE_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : cuieg_pkg

// File: hdl/cuieg_reg_if.sv
// Interface carrying register write and read strobes inside the unit
interface cuieg_reg_if;
   import cuieg_pkg::*;
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic [7:0] rdAddr;
   logic [31:0] rdData;
   logic rdErr;
   modport bus (output wrEn, wrAddr, wrData, wrStrb, rdAddr,
      input rdData, rdErr);
   modport regs (input wrEn, wrAddr, wrData, wrStrb, rdAddr,
      output rdData, rdErr);
endinterface : cuieg_reg_if

// File: verif/clock_unit_irq_enable_core_gates_tb.sv
// Self-checking bench for the clock unit enable and gate registers
module clock_unit_irq_enable_core_gates_tb
   import cuieg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic [3:0] wrLanes = 4'hF;
   logic [6:0] ev = 7'h00;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic leEn, dmaEn, aesEn;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int nMismatch = 0;
   int testsRun = 0;

   always #4 clk = ~clk;

   clock_unit_irq_enable_core_gates clock_unit_irq_enable_core_gates_i (
      .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .calibrationOverflow(ev[6]), .calibrationComplete(ev[5]),
      .auxFastRcOscReady(ev[4]), .slowCrystalOscReady(ev[3]),
      .slowRcOscReady(ev[2]), .fastCrystalOscReady(ev[1]),
      .fastRcOscReady(ev[0]), .irq(irq),
      .lowEnergyBusInterfaceClockEn(leEn), .dmaClockEn(dmaEn),
      .aesClockEn(aesEn));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles

   // Address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= wrLanes;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk(bresp, er);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      chk(rdata, exp);
      chk(rresp, er);
   endtask : rd

   task automatic pulse(input int i);
      @(posedge clk);
      ev <= 7'h01 << i;
      @(posedge clk);
      ev <= 7'h00;
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      rd(OFS_IRQ_ENABLE, 32'h0000_0000, RESP_OKAY);
      rd(OFS_CORE_GATE, 32'h0000_0000, RESP_OKAY);
      chk({leEn, dmaEn, aesEn}, 32'h0000_0000);
      chk(irq, 32'h0000_0000);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_gates;
      logic [2:0] v[5] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h0};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CORE_GATE, {29'h0, v[i]}, RESP_OKAY);
         cycles(2);
         chk({leEn, dmaEn, aesEn}, {29'h0, v[i]});
         rd(OFS_CORE_GATE, {29'h0, v[i]}, RESP_OKAY);
      end
      // Lane 0 off: the write is answered but leaves the gates alone
      wrLanes = 4'hE;
      wr(OFS_CORE_GATE, 32'h0000_0007, RESP_OKAY);
      wrLanes = 4'hF;
      cycles(2);
      chk({leEn, dmaEn, aesEn}, 32'h0000_0000);
      rd(OFS_CORE_GATE, 32'h0000_0000, RESP_OKAY);
      $display("test_gates done");
   endtask : test_gates

   // Each source: masked event keeps irq low, enabling it raises irq
   task automatic test_irq;
      logic [31:0] b;
      for (int i = 0; i < 7; i++) begin
         b = 32'h0000_0001 << i;
         wr(OFS_FLAG_CLEAR, 32'h0000_007F, RESP_OKAY);
         wr(OFS_IRQ_ENABLE, ~b & 32'h0000_007F, RESP_OKAY);
         pulse(i);
         cycles(3);
         chk(irq, 32'h0000_0000);
         rd(OFS_FLAG_STATUS, b, RESP_OKAY);
         wr(OFS_IRQ_ENABLE, b, RESP_OKAY);
         rd(OFS_IRQ_ENABLE, b, RESP_OKAY);
         cycles(3);
         chk(irq, 32'h0000_0001);
         wr(OFS_FLAG_CLEAR, b, RESP_OKAY);
         cycles(3);
         chk(irq, 32'h0000_0000);
      end
      wr(OFS_IRQ_ENABLE, 32'h0000_0000, RESP_OKAY);
      $display("test_irq done");
   endtask : test_irq

   task automatic test_setclr;
      wr(OFS_FLAG_SET, 32'h0000_007F, RESP_OKAY);
      rd(OFS_FLAG_STATUS, 32'h0000_007F, RESP_OKAY);
      wr(OFS_FLAG_CLEAR, 32'h0000_0055, RESP_OKAY);
      rd(OFS_FLAG_STATUS, 32'h0000_002A, RESP_OKAY);
      wr(OFS_FLAG_SET, 32'h0000_0000, RESP_OKAY);
      rd(OFS_FLAG_STATUS, 32'h0000_002A, RESP_OKAY);
      wr(OFS_FLAG_CLEAR, 32'h0000_0000, RESP_OKAY);
      rd(OFS_FLAG_STATUS, 32'h0000_002A, RESP_OKAY);
      wr(OFS_IRQ_ENABLE, 32'h0000_0008, RESP_OKAY);
      cycles(3);
      chk(irq, 32'h0000_0001);
      wr(OFS_FLAG_CLEAR, 32'h0000_007F, RESP_OKAY);
      rd(OFS_FLAG_STATUS, 32'h0000_0000, RESP_OKAY);
      // Unmapped place refused and leaves the gates alone
      wr(8'h44, 32'h0000_0007, RESP_SLVERR);
      rd(8'h44, 32'h0000_0000, RESP_SLVERR);
      rd(OFS_CORE_GATE, 32'h0000_0000, RESP_OKAY);
      $display("test_setclr done");
   endtask : test_setclr

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   initial begin
      #100000;
      nMismatch++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      test_reset();
      test_gates();
      test_irq();
      test_setclr();
      summarize();
   end
endmodule : clock_unit_irq_enable_core_gates_tb
